// ==== dbl_consts.svh ====
`ifndef DBL_CONSTS_SVH
`define DBL_CONSTS_SVH

// System clock rate.
`define DBL_CLK_MHZ 250

// Bus timing figures of the converter input latches, in ns.
`define DBL_T_SETUP_NS 60
`define DBL_T_HOLD_NS 20
`define DBL_T_WR_NS 60
`define DBL_T_OUTPUT_REGISTER_LOAD_N_NS 70

// Least times round up to whole clock cycles.
`define DBL_CYC_MIN(ns) ((((ns) * `DBL_CLK_MHZ) + 999) / 1000)
`define DBL_SETUP_CYC `DBL_CYC_MIN(`DBL_T_SETUP_NS)
`define DBL_HOLD_CYC `DBL_CYC_MIN(`DBL_T_HOLD_NS)
`define DBL_WR_CYC `DBL_CYC_MIN(`DBL_T_WR_NS)
`define DBL_OUTPUT_REGISTER_LOAD_N_CYC `DBL_CYC_MIN(`DBL_T_OUTPUT_REGISTER_LOAD_N_NS)

// Code widths and idle levels.
`define DBL_DATA_W 16
`define DBL_BYTE_W 8
`define DBL_TMR_W 8
`define DBL_STROBE_IDLE 1'b1

`endif

// ==== dbl_pkg.sv ====
package dbl_pkg;

    typedef enum logic [2:0] {
        DBL_IDLE = 3'h0,
        DBL_SETUP = 3'h1,
        DBL_PULSE = 3'h3,
        DBL_HOLD = 3'h2
    } dbl_state_type;

    typedef enum logic [1:0] {
        DBL_STEP_HI = 2'h0,
        DBL_STEP_LO = 2'h1,
        DBL_STEP_LD = 2'h2,
        DBL_STEP_W16 = 2'h3
    } dbl_step_type;

endpackage

// ==== dbl_tmr_if.sv ====
`timescale 1ns/1ps
interface dbl_tmr_if #(
    parameter int W = 8
);
    logic load;
    logic [W-1:0] val;
    logic expired;

    modport ctrl (
        output load,
        output val,
        input expired
    );

    modport tmr (
        input load,
        input val,
        output expired
    );
endinterface

// ==== dbl_timer.sv ====
`timescale 1ns/1ps
module dbl_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    dbl_tmr_if.tmr t
);

    logic [W-1:0] cnt_r;

    // A load of N makes expired rise N cycles after the load cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (t.load) begin
            cnt_r <= t.val - W'(1);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign t.expired = (cnt_r == '0);

endmodule

// ==== dbl_host.sv ====
`timescale 1ns/1ps
`include "dbl_consts.svh"

module dbl_host
    import dbl_pkg::*;
#(
    parameter int TW = `DBL_TMR_W,
    parameter bit UPPER_FIRST = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // User command port
    input wire logic wr_req,
    input wire logic [`DBL_DATA_W-1:0] wr_data,
    input wire logic bcast_req,
    input wire logic bus_mode_16,
    input wire logic sync_load,
    output logic busy,
    output logic done,
    // Converter pins
    output logic dac_cs_n,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic output_register_load_n,
    output logic [`DBL_DATA_W-1:0] dac_data
);

    localparam logic [TW-1:0] SETUP_CYC = TW'(`DBL_SETUP_CYC);
    localparam logic [TW-1:0] HOLD_CYC = TW'(`DBL_HOLD_CYC);
    localparam logic [TW-1:0] WR_CYC = TW'(`DBL_WR_CYC);
    localparam logic [TW-1:0] OUTPUT_REGISTER_LOAD_N_CYC = TW'(`DBL_OUTPUT_REGISTER_LOAD_N_CYC);
    localparam dbl_step_type FIRST_STEP = UPPER_FIRST ? DBL_STEP_HI : DBL_STEP_LO;
    localparam dbl_step_type SECOND_STEP = UPPER_FIRST ? DBL_STEP_LO : DBL_STEP_HI;

    // Active-high strobe set {upper, lower, load} for one write step.
    function automatic logic [2:0] dbl_strobes(input dbl_step_type s,
                                               input logic sync);
        logic [2:0] r;
        r = 3'h0;
        unique case (s)
            DBL_STEP_HI: r = {1'b1, 1'b0, sync && (s == SECOND_STEP)};
            DBL_STEP_LO: r = {1'b0, 1'b1, sync && (s == SECOND_STEP)};
            DBL_STEP_LD: r = 3'h1;
            DBL_STEP_W16: r = 3'h6;
        endcase
        return r;
    endfunction

    logic rst_meta_r;
    logic rst_n_r;
    dbl_state_type state_r, state_nxt;
    dbl_step_type step_r, step_nxt;
    logic [`DBL_DATA_W-1:0] wdata_r, wdata_nxt;
    logic sync_r, sync_nxt;
    logic mode16_r, mode16_nxt;
    logic busy_r, done_r, done_nxt;
    logic cs_n_r, ube_n_r, lbe_n_r, output_register_load_n_n_r;
    logic [`DBL_DATA_W-1:0] data_r;
    logic tmr_load;
    logic [TW-1:0] tmr_val;

    dbl_tmr_if #(.W(TW)) tmr ();

    dbl_timer #(.W(TW)) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n_r),
        .t(tmr)
    );

    assign tmr.load = tmr_load;
    assign tmr.val = tmr_val;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    wire start_wr = (state_r == DBL_IDLE) && wr_req;
    wire start_bc = (state_r == DBL_IDLE) && !wr_req && bcast_req && !bus_mode_16;
    // two byte writes, optional third load write
    wire last_step = (step_r == DBL_STEP_W16) || (step_r == DBL_STEP_LD) ||
                     ((step_r == SECOND_STEP) && sync_r);
    wire dbl_step_type after_step = (step_r == FIRST_STEP) ? SECOND_STEP
                                                           : DBL_STEP_LD;
    wire long_pulse = (step_r == DBL_STEP_LD) ||
                      ((step_r == SECOND_STEP) && sync_r);
    wire [TW-1:0] pulse_cyc = long_pulse ? OUTPUT_REGISTER_LOAD_N_CYC : WR_CYC;
    wire [`DBL_BYTE_W-1:0] hi_byte = wdata_r[`DBL_DATA_W-1:`DBL_BYTE_W];
    wire [`DBL_BYTE_W-1:0] lo_byte = wdata_r[`DBL_BYTE_W-1:0];

    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        wdata_nxt = wdata_r;
        sync_nxt = sync_r;
        mode16_nxt = mode16_r;
        done_nxt = 1'b0;
        tmr_load = 1'b0;
        tmr_val = SETUP_CYC;
        unique case (state_r)
            DBL_IDLE: begin
                mode16_nxt = bus_mode_16;
                if (start_wr || start_bc) begin
                    wdata_nxt = wr_data;
                    sync_nxt = sync_load;
                    step_nxt = start_bc ? DBL_STEP_LD
                             : (bus_mode_16 ? DBL_STEP_W16 : FIRST_STEP);
                    state_nxt = DBL_SETUP;
                    tmr_load = 1'b1;
                end
            end
            DBL_SETUP: begin
                if (tmr.expired) begin
                    state_nxt = DBL_PULSE;
                    tmr_load = 1'b1;
                    tmr_val = pulse_cyc;
                end
            end
            DBL_PULSE: begin
                if (tmr.expired) begin
                    state_nxt = DBL_HOLD;
                    tmr_load = 1'b1;
                    tmr_val = HOLD_CYC;
                end
            end
            DBL_HOLD: begin
                if (tmr.expired) begin
                    if (last_step) begin
                        state_nxt = DBL_IDLE;
                        done_nxt = 1'b1;
                    end else begin
                        step_nxt = after_step;
                        state_nxt = DBL_SETUP;
                        tmr_load = 1'b1;
                    end
                end
            end
            // Unused state codes fall back to idle; chip select and byte enables are released, load stays low on a sixteen-bit bus.
            default: begin
                state_nxt = DBL_IDLE;
            end
        endcase
    end

    // address on chip select, write strobe on enables
    wire cs_n_nxt = (state_nxt == DBL_IDLE);
    wire [2:0] strb_nxt = (state_nxt == DBL_PULSE) ?
                          dbl_strobes(step_nxt, sync_nxt) : 3'h0;
    // load held low on a sixteen-bit bus
    wire output_register_load_n_n_nxt = !(mode16_nxt || strb_nxt[0]);
    // code passed as offset binary; byte steps put the selected byte on both halves
    wire [`DBL_DATA_W-1:0] data_nxt =
        (step_nxt == DBL_STEP_HI) ? {hi_byte, hi_byte} :
        (step_nxt == DBL_STEP_LO) ? {lo_byte, lo_byte} : wdata_nxt;

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= DBL_IDLE;
            step_r <= DBL_STEP_HI;
            wdata_r <= 16'h0000;
            sync_r <= 1'b0;
            mode16_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            wdata_r <= wdata_nxt;
            sync_r <= sync_nxt;
            mode16_r <= mode16_nxt;
            busy_r <= (state_nxt != DBL_IDLE);
            done_r <= done_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cs_n_r <= `DBL_STROBE_IDLE;
            ube_n_r <= `DBL_STROBE_IDLE;
            lbe_n_r <= `DBL_STROBE_IDLE;
            output_register_load_n_n_r <= `DBL_STROBE_IDLE;
            data_r <= 16'h0000;
        end else begin
            // byte enables come from the pulse state alone, not gated by chip select
            cs_n_r <= cs_n_nxt;
            ube_n_r <= !strb_nxt[2];
            lbe_n_r <= !strb_nxt[1];
            output_register_load_n_n_r <= output_register_load_n_n_nxt;
            data_r <= data_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign dac_cs_n = cs_n_r;
    assign upper_byte_enable_n = ube_n_r;
    assign lower_byte_enable_n = lbe_n_r;
    assign output_register_load_n = output_register_load_n_n_r;
    assign dac_data = data_r;

endmodule

// ==== dbl_host_assertions.sv ====
`timescale 1ns/1ps
module dbl_host_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Watched outputs
    input wire logic busy,
    input wire logic done,
    input wire logic dac_cs_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic output_register_load_n,
    input wire logic [15:0] dac_data
);
    wire ub_n = upper_byte_enable_n;
    wire lb_n = lower_byte_enable_n;
    wire ld_n = output_register_load_n;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_enable_needs_cs: assert property ((!ub_n || !lb_n) |-> !dac_cs_n)
        else $error("byte enable low without chip select");
    a_setup_stable: assert property ((!ub_n || !lb_n) |-> $stable(dac_data))
        else $error("data moved while a byte enable was low");
    a_hold_stable: assert property (
        ($rose(ub_n) || $rose(lb_n)) |-> $stable(dac_data)[*5])
        else $error("data moved inside the hold time");
    a_upper_width: assert property ($fell(ub_n) |-> ##15 $rose(ub_n))
        else $error("upper enable pulse has the wrong width");
    a_lower_width: assert property ($fell(lb_n) |-> ##[15:18] $rose(lb_n))
        else $error("lower enable pulse has the wrong width");
    a_sync_pair: assert property (
        $fell(ld_n) && $fell(lb_n) |-> ##18 ($rose(ld_n) && $rose(lb_n)))
        else $error("load and second byte did not pulse together");
    a_load_width: assert property (
        $fell(ld_n) && lb_n && busy |-> ##18 $rose(ld_n))
        else $error("separate load pulse has the wrong width");
    a_both_bytes: assert property ((!ub_n && !ld_n) |-> !lb_n)
        else $error("full word write did not strobe both enables");
    a_byte_select: assert property ((!ub_n && !lb_n) |-> !ld_n)
        else $error("both byte enables low in a byte write");
    c_word: cover property ($fell(ub_n) && $fell(lb_n));
    c_sync: cover property ($fell(ld_n) && $fell(lb_n));
    c_done: cover property (done);
endmodule

bind dbl_host dbl_host_assertions dbl_host_assertions_i (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .busy(busy),
    .done(done),
    .dac_cs_n(dac_cs_n),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n),
    .output_register_load_n(output_register_load_n),
    .dac_data(dac_data)
);

// ==== dbl_dac_model.sv ====
`timescale 1ns/1ps
module dbl_dac_model (
    // Converter pins
    input wire logic cs_n,
    input wire logic ub_n,
    input wire logic lb_n,
    input wire logic ld_n,
    input wire logic [15:0] data,
    // Offset binary code of the output register
    output logic [15:0] code
);
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    always_latch begin
        if (!cs_n && !ub_n) begin
            hi_r <= data[15:8];
        end
    end
    always_latch begin
        if (!cs_n && !lb_n) begin
            lo_r <= data[7:0];
        end
    end
    always_latch begin
        if (!cs_n && !ld_n) begin
            code <= {hi_r, lo_r};
        end
    end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int S = 15;
    localparam int H = 5;
    localparam int PB = 15;
    localparam int PL = 18;
    logic sys_clk = 0;
    logic arst_n = 0;
    logic wr_req = 0;
    logic bcast_req = 0;
    logic bus_mode_16 = 0;
    logic sync_load = 0;
    logic [15:0] wr_data = 16'h0000;
    logic busy, done, cs_n, ub_n, lb_n, ld_n;
    logic [15:0] dac_data, code, mid;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    dbl_host dbl_host_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .wr_req(wr_req), .wr_data(wr_data), .bcast_req(bcast_req),
        .bus_mode_16(bus_mode_16), .sync_load(sync_load), .busy(busy),
        .done(done), .dac_cs_n(cs_n), .upper_byte_enable_n(ub_n),
        .lower_byte_enable_n(lb_n), .output_register_load_n(ld_n),
        .dac_data(dac_data));
    dbl_dac_model dbl_dac_model_i (.cs_n(cs_n), .ub_n(ub_n), .lb_n(lb_n),
        .ld_n(ld_n), .data(dac_data), .code(code));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic compare(input string what, input logic [15:0] exp, got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Issues one command and counts edges from the take to the done pulse.
    task automatic run(input logic bc, input logic [15:0] d);
        @(negedge sys_clk);
        wr_req = !bc;
        bcast_req = bc;
        wr_data = d;
        n = 0;
        mid = 16'hxxxx;
        @(negedge sys_clk);
        wr_req = 0;
        bcast_req = 0;
        compare("busy", 16'h0001, 16'(busy));
        compare("select", 16'h0000, 16'(cs_n));
        while (done !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
            if (n == 45) mid = code;
        end
        compare("idle busy", 16'h0000, 16'(busy));
    endtask
    task automatic t_w16;
        logic [15:0] v [3] = '{16'h0000, 16'hFFFF, 16'hA5C3};
        bus_mode_16 = 1;
        foreach (v[i]) begin
            run(0, v[i]);
            compare("word cycles", 16'(S + PB + H), 16'(n));
            compare("word code", v[i], code);
        end
    endtask
    task automatic t_w8(input logic s, input logic [15:0] d, old);
        logic [15:0] exp_n;
        exp_n = s ? 16'(2 * S + PB + PL + 2 * H)
                  : 16'(3 * S + 2 * PB + PL + 3 * H);
        bus_mode_16 = 0;
        sync_load = s;
        run(0, d);
        compare("byte cycles", exp_n, 16'(n));
        compare("held code", old, mid);
        compare("byte code", d, code);
    endtask
    task automatic t_bc;
        run(1, 16'h1234);
        compare("load cycles", 16'(S + PL + H), 16'(n));
        compare("load code", 16'h0001, code);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        arst_n = 1;
        repeat (3) @(negedge sys_clk);
        compare("idle strobes", 16'h000F, 16'({cs_n, ub_n, lb_n, ld_n}));
        t_w16();
        t_w8(1, 16'h8080, 16'hA5C3);
        t_w8(0, 16'h0001, 16'h8080);
        t_bc();
        wrap_up();
    end
endmodule
